//--- hdl/sdmd_pkg.sv
// constants for the sectored data memory decoder
package sdmd_pkg;
   localparam int SDMD_DATA_W = 8;
   localparam int SDMD_OFS_W = 8;
   localparam int SDMD_SEC_W = 3;
   localparam logic [7:0] SDMD_SFR_LAST = 8'h7f;
   localparam logic [7:0] SDMD_GP_FIRST = 8'h80;
   localparam int SDMD_TK_SEC_A = 5;
   localparam int SDMD_TK_SEC_B = 6;
   localparam logic [7:0] SDMD_TK_FIRST = 8'h00;
   localparam int SDMD_DEF_GP_SECTORS = 8;
   localparam int SDMD_DEF_TK_SIZE = 56;
   localparam logic [7:0] SDMD_UNUSED_VAL = 8'h00;
   localparam logic [7:0] SDMD_RESET_VAL = 8'h00;
   typedef enum logic [1:0] {
      SDMD_MODE_DIRECT,
      SDMD_MODE_PTR1,
      SDMD_MODE_PTR2,
      SDMD_MODE_EXT
   } sdmd_mode_e;
   typedef enum logic [1:0] {
      SDMD_OP_READ,
      SDMD_OP_WRITE,
      SDMD_OP_BSET,
      SDMD_OP_BCLR
   } sdmd_op_e;
   typedef enum {
      SDMD_RG_UNUSED,
      SDMD_RG_SFR,
      SDMD_RG_GP,
      SDMD_RG_TK
   } sdmd_region_e;
endpackage : sdmd_pkg

//--- hdl/sdmd_decoder.sv
// sectored data memory decoder with general, touch-key and special areas
// Functional notes
// - every location is one byte; all sectors share the byte-wide organisation
// - offsets 00H..7FH of special sectors decode to fixed special registers
// - offsets 80H..FFH of implemented sectors are general storage, touch-key sectors included
// - touch-key memory sits in sectors 5 and 6 from offset 00H
// - indirect access takes sector from pointer high, offset from pointer low
// - program bank select is ignored by the data memory decoder
// - extended address is 9 to 16 bits, high bits sector, low byte offset
// - extended access reaches any sector other than sector 0 directly
// - general locations take byte reads, writes, bit set and bit clear
// - protected special registers ignore writes
// - reads of unused special locations return 00H
`timescale 1ns/1ns
`default_nettype none
module sdmd_decoder #(
   parameter int GP_SECTORS = sdmd_pkg::SDMD_DEF_GP_SECTORS,
   parameter int TK_SIZE = sdmd_pkg::SDMD_DEF_TK_SIZE,
   parameter int EXT_ADDR_W = 11,
   parameter logic [127:0] SFR_IMPL = {128{1'b1}},
   parameter logic [127:0] SFR_PROT = '0
) (
   // clock and reset
   input wire logic clock_in,
   input wire logic reset_in,
   // access request from the core
   input wire logic req_in,
   input wire logic [1:0] mode_in,
   input wire logic [1:0] op_in,
   input wire logic [7:0] direct_ofs_in,
   input wire logic [EXT_ADDR_W-1:0] ext_addr_in,
   input wire logic [2:0] bit_sel_in,
   input wire logic [sdmd_pkg::SDMD_DATA_W-1:0] wdata_in,
   // pointer pairs and bank select
   input wire logic [7:0] pointer_one_sector_reg_in,
   input wire logic [7:0] pointer_one_offset_reg_in,
   input wire logic [7:0] pointer_two_sector_reg_in,
   input wire logic [7:0] pointer_two_offset_reg_in,
   input wire logic [7:0] program_bank_select_in,
   // answer
   output logic ack_out,
   output logic [sdmd_pkg::SDMD_DATA_W-1:0] rdata_out,
   output logic [1:0] region_out
);
   import sdmd_pkg::*;

   initial begin
      // touch-key regions must stay below the general area, so at most 128 bytes each
      if (GP_SECTORS < 1 || GP_SECTORS > 256 || TK_SIZE < 1 || TK_SIZE > 128 ||
          EXT_ADDR_W < 9 || EXT_ADDR_W > 16) begin
         $error("sdmd_decoder: unsupported parameters");
      end
   end

   localparam int GP_WORDS = GP_SECTORS * 128;
   localparam int SFR_SECTORS = 2;

   // one byte per location, shared by every sector
   logic [SDMD_DATA_W-1:0] gp_mem [GP_WORDS];
   logic [SDMD_DATA_W-1:0] tk_mem [2*TK_SIZE];
   logic [SDMD_DATA_W-1:0] sfr_mem [SFR_SECTORS*128];

   logic [7:0] sec;
   logic [7:0] ofs;
   logic ext_bad;
   sdmd_region_e region;
   logic [SDMD_DATA_W-1:0] cur;
   logic [SDMD_DATA_W-1:0] newv;
   logic do_write;
   logic ack_nxt;
   logic [SDMD_DATA_W-1:0] rdata_nxt;
   logic [1:0] region_nxt;
   logic ack_r;
   logic [SDMD_DATA_W-1:0] rdata_r;
   logic [1:0] region_r;

   function automatic logic [SDMD_DATA_W-1:0] apply_op(input logic [1:0] op,
         input logic [SDMD_DATA_W-1:0] old, input logic [SDMD_DATA_W-1:0] wd,
         input logic [2:0] b);
      logic [SDMD_DATA_W-1:0] m;
      m = SDMD_DATA_W'(1) << b;
      case (op)
         SDMD_OP_WRITE: apply_op = wd;
         SDMD_OP_BSET: apply_op = old | m;
         SDMD_OP_BCLR: apply_op = old & ~m;
         default: apply_op = old;
      endcase
   endfunction : apply_op

   // address source: the bank select input is never read here
   always_comb begin
      sec = 8'h00;
      ofs = direct_ofs_in;
      ext_bad = 1'b0;
      case (mode_in)
         SDMD_MODE_PTR1: begin
            sec = pointer_one_sector_reg_in;
            ofs = pointer_one_offset_reg_in;
         end
         SDMD_MODE_PTR2: begin
            sec = pointer_two_sector_reg_in;
            ofs = pointer_two_offset_reg_in;
         end
         SDMD_MODE_EXT: begin
            sec = 8'(ext_addr_in[EXT_ADDR_W-1:8]);
            ofs = ext_addr_in[7:0];
            ext_bad = (sec == 8'h00);
         end
         default: begin
            sec = 8'h00;
            ofs = direct_ofs_in;
         end
      endcase
   end

   // region decode; anything beyond capacity falls into unused
   always_comb begin
      region = SDMD_RG_UNUSED;
      if (ext_bad) begin
         region = SDMD_RG_UNUSED;
      end else if (ofs >= SDMD_GP_FIRST) begin
         if (32'(sec) < GP_SECTORS) region = SDMD_RG_GP;
      end else if ((32'(sec) == SDMD_TK_SEC_A || 32'(sec) == SDMD_TK_SEC_B) &&
                   ofs >= SDMD_TK_FIRST && 32'(ofs) < TK_SIZE) begin
         region = SDMD_RG_TK;
      end else if (32'(sec) < SFR_SECTORS && ofs <= SDMD_SFR_LAST) begin
         if (SFR_IMPL[ofs[6:0]]) region = SDMD_RG_SFR;
      end
   end

   always_comb begin
      cur = SDMD_UNUSED_VAL;
      case (region)
         SDMD_RG_GP: cur = gp_mem[{sec, ofs[6:0]} % GP_WORDS];
         SDMD_RG_TK: cur = tk_mem[(32'(sec == 8'(SDMD_TK_SEC_B)) * TK_SIZE + 32'(ofs))
                                  % (2*TK_SIZE)];
         SDMD_RG_SFR: cur = sfr_mem[{sec[0], ofs[6:0]}];
         default: cur = SDMD_UNUSED_VAL;
      endcase
      newv = apply_op(op_in, cur, wdata_in, bit_sel_in);
      do_write = req_in && (op_in != SDMD_OP_READ) && (region != SDMD_RG_UNUSED) &&
                 !(region == SDMD_RG_SFR && SFR_PROT[ofs[6:0]]);
      ack_nxt = req_in;
      rdata_nxt = req_in ? cur : rdata_r;
      region_nxt = req_in ? 2'(region) : region_r;
   end

   always_ff @(posedge clock_in) begin
      if (do_write) begin
         case (region)
            SDMD_RG_GP: gp_mem[{sec, ofs[6:0]} % GP_WORDS] <= newv;
            SDMD_RG_TK: tk_mem[(32'(sec == 8'(SDMD_TK_SEC_B)) * TK_SIZE + 32'(ofs))
                               % (2*TK_SIZE)] <= newv;
            default: sfr_mem[{sec[0], ofs[6:0]}] <= newv;
         endcase
      end
   end

   always_ff @(posedge clock_in) begin
      if (reset_in) begin
         ack_r <= 1'b0;
         rdata_r <= SDMD_RESET_VAL;
         region_r <= 2'(SDMD_RG_UNUSED);
      end else begin
         ack_r <= ack_nxt;
         rdata_r <= rdata_nxt;
         region_r <= region_nxt;
      end
   end

   assign ack_out = ack_r;
   assign rdata_out = rdata_r;
   assign region_out = region_r;

   property p_unused_zero;
      @(posedge clock_in) disable iff (reset_in)
      (req_in && region == SDMD_RG_UNUSED) |=> (rdata_out == 8'h00);
   endproperty
   AST_UNUSED_ZERO: assert property (p_unused_zero) else $error("unused read not zero");

   AST_EXT_SEC0: assert property (@(posedge clock_in) disable iff (reset_in)
      (req_in && mode_in == SDMD_MODE_EXT && ext_addr_in[EXT_ADDR_W-1:8] == '0)
      |=> region_out == 2'(SDMD_RG_UNUSED)) else $error("ext sector 0 decoded");

   AST_PROT_NOWR: assert property (@(posedge clock_in) disable iff (reset_in)
      (region == SDMD_RG_SFR && SFR_PROT[ofs[6:0]]) |-> !do_write)
      else $error("protected register written");

   AST_GP_HIGH: assert property (@(posedge clock_in) disable iff (reset_in)
      (req_in && region == SDMD_RG_GP) |-> (ofs >= 8'h80 && 32'(sec) < GP_SECTORS))
      else $error("general decode wrong");

   AST_TK_MAP: assert property (@(posedge clock_in) disable iff (reset_in)
      (req_in && region == SDMD_RG_TK) |-> ((sec == 8'd5 || sec == 8'd6) && ofs < 8'h80))
      else $error("touch-key decode wrong");

   AST_SFR_LOW: assert property (@(posedge clock_in) disable iff (reset_in)
      (req_in && region == SDMD_RG_SFR) |-> (ofs <= 8'h7f && sec < 8'd2))
      else $error("special decode wrong");

   sequence s_ptr1_req;
      req_in && mode_in == SDMD_MODE_PTR1;
   endsequence
   AST_PTR1_SRC: assert property (@(posedge clock_in) disable iff (reset_in)
      s_ptr1_req |-> (sec == pointer_one_sector_reg_in && ofs == pointer_one_offset_reg_in))
      else $error("pointer source wrong");

   AST_ACK_ONE: assert property (@(posedge clock_in) disable iff (reset_in)
      req_in |=> ack_out) else $error("missing ack");

   AST_BSET_WR: assert property (@(posedge clock_in) disable iff (reset_in)
      (req_in && op_in == SDMD_OP_BSET && region == SDMD_RG_GP) |-> newv[bit_sel_in])
      else $error("bit set wrong");

   AST_DIRECT_SEC0: assert property (@(posedge clock_in) disable iff (reset_in)
      (req_in && mode_in == SDMD_MODE_DIRECT) |-> sec == 8'h00)
      else $error("direct sector not zero");

   // read data and region stand until the next request, so the core may sample late; ack is high the cycle after each request cycle
   AST_ACK_PULSE: assert property (@(posedge clock_in) disable iff (reset_in)
      !req_in |=> !ack_out) else $error("ack without request");

   AST_RD_HOLD: assert property (@(posedge clock_in) disable iff (reset_in)
      !req_in |=> ($stable(rdata_out) && $stable(region_out)))
      else $error("answer not held");
endmodule : sdmd_decoder
`default_nettype wire

//--- tb/sdmd_core_model.sv
// core-side model issuing data memory accesses
`timescale 1ns/1ns
`default_nettype none
module sdmd_core_model (
   // clock
   input wire logic clock_in,
   // access request
   output logic req_out,
   output logic [1:0] mode_out,
   output logic [1:0] op_out,
   output logic [7:0] dofs_out,
   output logic [10:0] ext_out,
   output logic [2:0] bit_out,
   output logic [7:0] wd_out,
   // pointer pairs and bank select
   output logic [7:0] p1s_out,
   output logic [7:0] p1o_out,
   output logic [7:0] p2s_out,
   output logic [7:0] p2o_out,
   output logic [7:0] bank_out
);
   initial begin
      {req_out, mode_out, op_out, dofs_out, ext_out, bit_out, wd_out} = '0;
      {p1s_out, p1o_out, p2s_out, p2o_out, bank_out} = '0;
   end
   // unselected fields carry the inverse so a wrong source cannot match by chance
   task automatic access(input logic [1:0] m, input logic [1:0] o, input logic [7:0] s,
         input logic [7:0] a, input logic [7:0] d);
      @(negedge clock_in);
      req_out = 1'b1;
      mode_out = m;
      op_out = o;
      wd_out = d;
      bit_out = d[2:0];
      dofs_out = (m == 2'd0) ? a : ~a;
      p1s_out = (m == 2'd1) ? s : ~s;
      p1o_out = (m == 2'd1) ? a : ~a;
      p2s_out = (m == 2'd2) ? s : ~s;
      p2o_out = (m == 2'd2) ? a : ~a;
      ext_out = (m == 2'd3) ? {s[2:0], a} : ~{s[2:0], a};
      bank_out = ~bank_out;
      @(negedge clock_in);
      req_out = 1'b0;
   endtask : access
endmodule : sdmd_core_model
`default_nettype wire

//--- tb/test_sectored_data_memory_decoder.sv
// testbench for the sectored data memory decoder
`timescale 1ns/1ns
`default_nettype none
module test_sectored_data_memory_decoder;
   import sdmd_pkg::*;
   logic clock_in = 1'b0;
   logic reset_in = 1'b1;
   logic req, ack;
   logic [1:0] mode, op, region;
   logic [7:0] dofs, wd, p1s, p1o, p2s, p2o, bank, rdata;
   logic [10:0] ext;
   logic [2:0] bsel;
   int num_errors = 0;
   int checks_done = 0;
   initial begin
      forever #4 clock_in = ~clock_in;
   end
   sdmd_decoder #(.SFR_IMPL(~(128'h1 << 32)), .SFR_PROT(128'h1 << 48)) dut_u (
      .clock_in(clock_in), .reset_in(reset_in), .req_in(req), .mode_in(mode),
      .op_in(op), .direct_ofs_in(dofs), .ext_addr_in(ext), .bit_sel_in(bsel),
      .wdata_in(wd), .pointer_one_sector_reg_in(p1s), .pointer_one_offset_reg_in(p1o),
      .pointer_two_sector_reg_in(p2s), .pointer_two_offset_reg_in(p2o),
      .program_bank_select_in(bank), .ack_out(ack), .rdata_out(rdata), .region_out(region));
   sdmd_core_model core_u (
      .clock_in(clock_in), .req_out(req), .mode_out(mode), .op_out(op), .dofs_out(dofs),
      .ext_out(ext), .bit_out(bsel), .wd_out(wd), .p1s_out(p1s), .p1o_out(p1o),
      .p2s_out(p2s), .p2o_out(p2o), .bank_out(bank));
   task automatic chk(input string n, input logic [7:0] got, input logic [7:0] exp);
      checks_done++;
      if (got !== exp) begin
         num_errors++;
         $display("ERROR %s expected %h seen %h", n, exp, got);
      end
   endtask : chk
   // an unknown expectation skips that field, for locations never written
   task automatic acc(input logic [1:0] m, input logic [1:0] o, input logic [7:0] s,
         input logic [7:0] a, input logic [7:0] d, input logic [7:0] er, input logic [1:0] eg);
      core_u.access(m, o, s, a, d);
      chk("ack", {7'h0, ack}, 8'h01);
      if (!$isunknown(er)) chk("rdata", rdata, er);
      if (!$isunknown(eg)) chk("region", {6'h0, region}, {6'h0, eg});
      @(negedge clock_in);
      chk("ack_low", {7'h0, ack}, 8'h00);
      if (!$isunknown(er)) chk("rdata_hold", rdata, er);
   endtask : acc
   task automatic summarize;
      $display("checks %0d errors %0d", checks_done, num_errors);
      if (num_errors == 0 && checks_done > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : summarize
   task automatic t_general;
      acc(1, SDMD_OP_WRITE, 8'h02, 8'h90, 8'haa, 8'hxx, 2'd2);
      acc(2, SDMD_OP_BSET, 8'h02, 8'h90, 8'h00, 8'haa, 2'd2);
      acc(1, SDMD_OP_BCLR, 8'h02, 8'h90, 8'h01, 8'hab, 2'd2);
      acc(3, SDMD_OP_READ, 8'h02, 8'h90, 8'h00, 8'ha9, 2'd2);
      acc(0, SDMD_OP_WRITE, 8'h00, 8'hff, 8'h81, 8'hxx, 2'd2);
      acc(1, SDMD_OP_READ, 8'h00, 8'hff, 8'h00, 8'h81, 2'd2);
   endtask : t_general
   task automatic t_extended;
      acc(3, SDMD_OP_WRITE, 8'h03, 8'h85, 8'h5c, 8'hxx, 2'd2);
      acc(1, SDMD_OP_READ, 8'h03, 8'h85, 8'h00, 8'h5c, 2'd2);
      acc(0, SDMD_OP_WRITE, 8'h00, 8'h90, 8'h42, 8'hxx, 2'd2);
      acc(3, SDMD_OP_WRITE, 8'h00, 8'h90, 8'h77, 8'h00, 2'd0);
      acc(0, SDMD_OP_READ, 8'h00, 8'h90, 8'h00, 8'h42, 2'd2);
   endtask : t_extended
   task automatic t_touch;
      for (int s = SDMD_TK_SEC_A; s <= SDMD_TK_SEC_B; s++) begin
         acc(1, SDMD_OP_WRITE, 8'(s), 8'h37, 8'(s), 8'hxx, 2'd3);
         acc(2, SDMD_OP_READ, 8'(s), 8'h37, 8'h00, 8'(s), 2'd3);
         acc(1, SDMD_OP_WRITE, 8'(s), 8'h38, 8'h44, 8'h00, 2'd0);
         acc(1, SDMD_OP_READ, 8'(s), 8'h38, 8'h00, 8'h00, 2'd0);
      end
      acc(1, SDMD_OP_WRITE, 8'h08, 8'h80, 8'h11, 8'h00, 2'd0);
      acc(1, SDMD_OP_READ, 8'h08, 8'h80, 8'h00, 8'h00, 2'd0);
      acc(2, SDMD_OP_READ, 8'h02, 8'h10, 8'h00, 8'h00, 2'd0);
   endtask : t_touch
   task automatic t_special;
      acc(0, SDMD_OP_WRITE, 8'h00, 8'h7f, 8'h3c, 8'hxx, 2'd1);
      acc(0, SDMD_OP_READ, 8'h00, 8'h7f, 8'h00, 8'h3c, 2'd1);
      acc(0, SDMD_OP_WRITE, 8'h00, 8'h40, 8'hc3, 8'hxx, 2'd1);
      acc(1, SDMD_OP_WRITE, 8'h01, 8'h40, 8'h5a, 8'hxx, 2'd1);
      acc(0, SDMD_OP_READ, 8'h00, 8'h40, 8'h00, 8'hc3, 2'd1);
      acc(2, SDMD_OP_READ, 8'h01, 8'h40, 8'h00, 8'h5a, 2'd1);
      acc(0, SDMD_OP_WRITE, 8'h00, 8'h30, 8'ha5, 8'hxx, 2'd1);
      acc(0, SDMD_OP_READ, 8'h00, 8'h30, 8'h00, 8'hxx, 2'd1);
      chk("protected", {7'h0, rdata === 8'ha5}, 8'h00);
      acc(0, SDMD_OP_WRITE, 8'h00, 8'h20, 8'h99, 8'h00, 2'd0);
      acc(0, SDMD_OP_READ, 8'h00, 8'h20, 8'h00, 8'h00, 2'd0);
   endtask : t_special
   initial begin
      repeat (8) @(negedge clock_in);
      reset_in = 1'b0;
      t_general();
      t_extended();
      t_touch();
      t_special();
      summarize();
   end
   // about twenty-four times the expected run length
   initial begin
      #20000;
      num_errors++;
      summarize();
   end
endmodule : test_sectored_data_memory_decoder
`default_nettype wire
